// [pgs_ext_mem.sv]
// Storage for the extended register set with a registered read port
module pgs_ext_mem #(
   parameter int AW = 8,
   parameter int DW = 16
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // Write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   // Read port, data one cycle after rd_en
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [DW-1:0] rd_data
);
   // Array contents are not cleared by reset
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Write side
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read side, output held in a register
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// [pgs_pkg.sv]
// Constants and types shared by the gigabit status and extended access block
package pgs_pkg;
   // Register offsets on the management interface
   localparam logic [4:0]  PGS_OFS_LINK_STATUS = 5'h0a;
   localparam logic [4:0]  PGS_OFS_ACC_CTRL    = 5'h0d;
   localparam logic [4:0]  PGS_OFS_ADDR_DATA   = 5'h0e;
   localparam logic [4:0]  PGS_OFS_CAPAB       = 5'h0f;
   // Highest directly reachable register address
   localparam logic [4:0]  PGS_OFS_DIRECT_MAX  = 5'h1f;
   // Field positions in the extended access control register
   localparam int          PGS_FUNC_MSB        = 15;
   localparam int          PGS_FUNC_LSB        = 14;
   localparam int          PGS_TARGET_DEVICE_ADDRESS_MSB       = 4;
   localparam int          PGS_TARGET_DEVICE_ADDRESS_LSB       = 0;
   // Function select codes
   localparam logic [1:0]  PGS_FUNC_ADDR       = 2'h0;
   localparam logic [1:0]  PGS_FUNC_DATA       = 2'h1;
   localparam logic [1:0]  PGS_FUNC_INC_RW     = 2'h2;
   localparam logic [1:0]  PGS_FUNC_INC_WR     = 2'h3;
   // Device address that selects the extended register set
   localparam logic [4:0]  PGS_EXT_TARGET_DEVICE_ADDRESS       = 5'h1f;
   // Reset values
   localparam logic [1:0]  PGS_FUNC_RST        = 2'h0;
   localparam logic [4:0]  PGS_TARGET_DEVICE_ADDRESS_RST       = 5'h00;
   localparam logic [15:0] PGS_PTR_RST         = 16'h0000;
   localparam logic [7:0]  PGS_IDLE_RST        = 8'h00;
   // Capability register: twisted-pair full and half duplex only
   localparam logic [15:0] PGS_CAPAB_VALUE     = 16'h3000;
   // Width of the idle error counter
   localparam int          PGS_IDLE_W          = 8;
   // Serial management frame layout
   localparam logic [5:0]  PGS_PRE_LEN         = 6'h20;
   localparam logic [4:0]  PGS_HDR_LAST        = 5'h0c;
   localparam logic [4:0]  PGS_TA_LAST         = 5'h01;
   localparam logic [4:0]  PGS_DATA_LAST       = 5'h0f;
   localparam logic [1:0]  PGS_OP_READ         = 2'h2;
   localparam logic [1:0]  PGS_OP_WRITE        = 2'h1;
   // Frame receiver states
   typedef enum logic [1:0] {
      PGS_S_PRE,
      PGS_S_HDR,
      PGS_S_TA,
      PGS_S_DATA
   } pgs_state_t;
endpackage

// [pgs_regbank.sv]
// Gigabit status, capability and indirect extended access registers
module pgs_regbank #(
   parameter int EXT_AW = 8
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Serial management pins
   input  wire logic       mdc,
   input  wire logic       mdio_i,
   output logic            mdio_o,
   output logic            mdio_oe,
   // Strapped management address
   input  wire logic [4:0] phy_addr,
   // Status from the gigabit receive logic
   input  wire logic       ms_fault_evt,
   input  wire logic       ms_is_master,
   input  wire logic       local_rx_ok,
   input  wire logic       remote_rx_ok,
   input  wire logic       lp_gig_fd,
   input  wire logic       lp_gig_hd,
   input  wire logic       idle_err_evt
);
   import pgs_pkg::*;

   // True for the function codes that access extended data
   function automatic logic is_data_mode(input logic [1:0] f);
      is_data_mode = (f != PGS_FUNC_ADDR);
   endfunction

   // True when the pointer steps after an access of this kind
   function automatic logic steps_ptr(input logic [1:0] f,
                                      input logic       is_wr);
      case (f)
         PGS_FUNC_INC_RW: steps_ptr = 1'b1;
         PGS_FUNC_INC_WR: steps_ptr = is_wr;
         default:         steps_ptr = 1'b0;
      endcase
   endfunction

   // Synchronised pins
   logic [6:0]            pin_sync;        // {phy_addr, mdio, mdc}
   logic                  mdc_s;           // Synchronised clock level
   logic                  mdio_s;          // Synchronised data level
   logic [4:0]            phy_addr_s;      // Synchronised strap
   logic                  mdc_d_reg;       // Previous clock level
   logic                  mdc_rise;        // One-cycle rising edge

   // Frame receiver state
   pgs_state_t            st_reg;          // Current frame phase
   logic [4:0]            cnt_reg;         // Bit count in phase
   logic [5:0]            ones_reg;        // Consecutive preamble ones
   logic [15:0]           sr_reg;          // Incoming shift register
   logic [15:0]           out_reg;         // Outgoing shift register
   logic [4:0]            regad_reg;       // Register of this frame
   logic                  is_rd_reg;       // Frame is a read
   logic                  mdio_o_reg;      // Driven data bit
   logic                  mdio_oe_reg;     // Drive enable

   // Register state
   logic                  fault_reg;       // Latched fault flag
   logic [PGS_IDLE_W-1:0] idle_reg;        // Idle error count
   logic [1:0]            func_reg;        // Function select
   logic [4:0]            target_device_address_reg;       // Target device address
   logic [15:0]           ptr_reg;         // Extended pointer

   // Decoded strobes and selects
   logic [12:0]           hdr_w;           // Header with newest bit
   logic                  hdr_done;        // Last header bit seen
   logic                  hdr_ok;          // Header is ours and valid
   logic                  rd_fire;         // Read value taken now
   logic                  wr_fire;         // Write committed now
   logic [15:0]           wr_data;         // Complete write word
   logic                  sel_ls;          // Frame targets link status
   logic                  sel_acc;         // Frame targets access ctrl
   logic                  sel_ad;          // Frame targets address/data
   logic                  target_device_address_ok;        // Extended set is addressed
   logic                  data_mode;       // Function is a data mode
   logic                  ptr_load;        // Pointer load strobe
   logic                  ptr_inc;         // Pointer step strobe
   logic                  ext_wr;          // Extended register write
   logic                  ext_rd;          // Extended register read
   logic                  ls_clr;          // Clear-on-read strobe
   logic [15:0]           ls_word;         // Link status read value
   logic [15:0]           acc_word;        // Access control read value
   logic [15:0]           ad_word;         // Address/data read value
   logic [15:0]           ext_rdata;       // Extended memory data
   logic [15:0]           rd_mux;          // Selected read value
   logic                  idle_full;       // Counter at all ones

   // Pin synchronisers
   pgs_sync #(
      .W (7)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({phy_addr, mdio_i, mdc}),
      .q   (pin_sync)
   );

   assign mdc_s      = pin_sync[0];
   assign mdio_s     = pin_sync[1];
   assign phy_addr_s = pin_sync[6:2];

   // Edge detect on the synchronised management clock
   always_ff @(posedge clk) begin
      if (rst) begin
         mdc_d_reg <= 1'b0;
      end else begin
         mdc_d_reg <= mdc_s;
      end
   end

   assign mdc_rise = mdc_s & ~mdc_d_reg;

   // Header decode: start, opcode, our address
   assign hdr_w    = {sr_reg[11:0], mdio_s};
   assign hdr_done = mdc_rise & (st_reg == PGS_S_HDR)
                   & (cnt_reg == PGS_HDR_LAST);
   assign hdr_ok   = hdr_w[12] & (hdr_w[9:5] == phy_addr_s)
                   & ((hdr_w[11:10] == PGS_OP_READ)
                   | (hdr_w[11:10] == PGS_OP_WRITE));

   // Read value is taken at the turnaround, write at the last bit
   assign rd_fire  = mdc_rise & (st_reg == PGS_S_TA)
                   & (cnt_reg == 5'h00) & is_rd_reg;
   assign wr_fire  = mdc_rise & (st_reg == PGS_S_DATA)
                   & (cnt_reg == PGS_DATA_LAST) & ~is_rd_reg;
   assign wr_data  = {sr_reg[14:0], mdio_s};

   // Register selects
   assign sel_ls   = (regad_reg == PGS_OFS_LINK_STATUS);
   assign sel_acc  = (regad_reg == PGS_OFS_ACC_CTRL);
   assign sel_ad   = (regad_reg == PGS_OFS_ADDR_DATA);

   // Indirect path qualifiers
   assign target_device_address_ok  = (target_device_address_reg == PGS_EXT_TARGET_DEVICE_ADDRESS);
   assign data_mode = is_data_mode(func_reg);

   // Pointer load only in address mode
   assign ptr_load = wr_fire & sel_ad & target_device_address_ok
                   & ~data_mode;
   // Pointer step after a data access, per function select
   assign ptr_inc  = sel_ad & target_device_address_ok & data_mode
                   & ((wr_fire & steps_ptr(func_reg, 1'b1))
                   | (rd_fire & steps_ptr(func_reg, 1'b0)));
   // Extended register accesses through the data window
   assign ext_wr   = wr_fire & sel_ad & target_device_address_ok & data_mode;
   assign ext_rd   = hdr_done & hdr_ok
                   & (hdr_w[4:0] == PGS_OFS_ADDR_DATA);

   // Clear-on-read of the link status register
   assign ls_clr   = rd_fire & sel_ls;

   // Read values of each register
   assign ls_word  = {fault_reg, ms_is_master,
                      local_rx_ok, remote_rx_ok,
                      lp_gig_fd, lp_gig_hd,
                      2'h0,
                      idle_reg};
   assign acc_word = {func_reg, 9'h000, target_device_address_reg};
   assign ad_word  = ~target_device_address_ok  ? 16'h0000 :
                     data_mode  ? ext_rdata : ptr_reg;

   // Read multiplexer; unlisted offsets read zero
   assign rd_mux   = sel_ls  ? ls_word  :
                     sel_acc ? acc_word :
                     sel_ad  ? ad_word  :
                     (regad_reg == PGS_OFS_CAPAB) ? PGS_CAPAB_VALUE :
                     16'h0000;

   assign idle_full = &idle_reg;

   // Extended register storage, indexed by the low pointer bits
   pgs_ext_mem #(
      .AW (EXT_AW),
      .DW (16)
   ) u_mem (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (ext_wr),
      .wr_addr (ptr_reg[EXT_AW-1:0]),
      .wr_data (wr_data),
      .rd_en   (ext_rd),
      .rd_addr (ptr_reg[EXT_AW-1:0]),
      .rd_data (ext_rdata)
   );

   // Frame receiver: preamble, header, turnaround, data
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg    <= PGS_S_PRE;
         cnt_reg   <= 5'h00;
         ones_reg  <= 6'h00;
         sr_reg    <= 16'h0000;
         regad_reg <= 5'h00;
         is_rd_reg <= 1'b0;
      end else if (mdc_rise) begin
         case (st_reg)
            // Count ones; a zero after a full preamble starts a frame
            PGS_S_PRE: begin
               if (mdio_s) begin
                  if (ones_reg != PGS_PRE_LEN) begin
                     ones_reg <= ones_reg + 6'h01;
                  end
               end else if (ones_reg == PGS_PRE_LEN) begin
                  st_reg  <= PGS_S_HDR;
                  cnt_reg <= 5'h00;
                  sr_reg  <= 16'h0000;
               end else begin
                  ones_reg <= 6'h00;
               end
            end
            // Shift start, opcode and both addresses
            PGS_S_HDR: begin
               sr_reg  <= {sr_reg[14:0], mdio_s};
               cnt_reg <= cnt_reg + 5'h01;
               if (cnt_reg == PGS_HDR_LAST) begin
                  ones_reg <= 6'h00;
                  cnt_reg  <= 5'h00;
                  if (hdr_ok) begin
                     st_reg    <= PGS_S_TA;
                     regad_reg <= hdr_w[4:0];
                     is_rd_reg <= (hdr_w[11:10] == PGS_OP_READ);
                  end else begin
                     // Not ours: wait for a fresh preamble
                     st_reg <= PGS_S_PRE;
                  end
               end
            end
            // Two turnaround bits
            PGS_S_TA: begin
               cnt_reg <= cnt_reg + 5'h01;
               if (cnt_reg == PGS_TA_LAST) begin
                  st_reg  <= PGS_S_DATA;
                  cnt_reg <= 5'h00;
               end
            end
            // Sixteen data bits, most significant first
            PGS_S_DATA: begin
               sr_reg  <= {sr_reg[14:0], mdio_s};
               cnt_reg <= cnt_reg + 5'h01;
               if (cnt_reg == PGS_DATA_LAST) begin
                  st_reg  <= PGS_S_PRE;
                  cnt_reg <= 5'h00;
               end
            end
            default: begin
               st_reg <= PGS_S_PRE;
            end
         endcase
      end
   end

   // Read data driver: zero in the second turnaround bit, then data
   always_ff @(posedge clk) begin
      if (rst) begin
         out_reg     <= 16'h0000;
         mdio_o_reg  <= 1'b0;
         mdio_oe_reg <= 1'b0;
      end else if (rd_fire) begin
         out_reg     <= rd_mux;
         mdio_o_reg  <= 1'b0;
         mdio_oe_reg <= 1'b1;
      end else if (mdc_rise & mdio_oe_reg) begin
         if ((st_reg == PGS_S_DATA) & (cnt_reg == PGS_DATA_LAST)) begin
            // Release the line after the last data bit
            mdio_oe_reg <= 1'b0;
            mdio_o_reg  <= 1'b0;
         end else begin
            mdio_o_reg <= out_reg[15];
            out_reg    <= {out_reg[14:0], 1'b0};
         end
      end
   end

   assign mdio_o  = mdio_o_reg;
   assign mdio_oe = mdio_oe_reg;

   // Fault flag: a new fault wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         fault_reg <= 1'b0;
      end else begin
         fault_reg <= ms_fault_evt | (fault_reg & ~ls_clr);
      end
   end

   // Idle error counter: saturating, cleared on read, event kept
   always_ff @(posedge clk) begin
      if (rst) begin
         idle_reg <= PGS_IDLE_RST;
      end else if (ls_clr) begin
         idle_reg <= idle_err_evt ? {{(PGS_IDLE_W-1){1'b0}}, 1'b1}
                                  : PGS_IDLE_RST;
      end else if (idle_err_evt & ~idle_full) begin
         idle_reg <= idle_reg + {{(PGS_IDLE_W-1){1'b0}}, 1'b1};
      end
   end

   // Access control register; reserved bits are not stored
   always_ff @(posedge clk) begin
      if (rst) begin
         func_reg  <= PGS_FUNC_RST;
         target_device_address_reg <= PGS_TARGET_DEVICE_ADDRESS_RST;
      end else if (wr_fire & sel_acc) begin
         func_reg  <= wr_data[PGS_FUNC_MSB:PGS_FUNC_LSB];
         target_device_address_reg <= wr_data[PGS_TARGET_DEVICE_ADDRESS_MSB:PGS_TARGET_DEVICE_ADDRESS_LSB];
      end
   end

   // Extended pointer: loaded in address mode, stepped after access
   always_ff @(posedge clk) begin
      if (rst) begin
         ptr_reg <= PGS_PTR_RST;
      end else if (ptr_load) begin
         ptr_reg <= wr_data;
      end else if (ptr_inc) begin
         ptr_reg <= ptr_reg + 16'h0001;
      end
   end

endmodule

// [pgs_regbank_chk.sv]
// Port-level assertions for the gigabit status and extended access block
module pgs_chk (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Management pins
   input wire logic       mdc,
   input wire logic       mdio_i,
   input wire logic       mdio_o,
   input wire logic       mdio_oe,
   input wire logic [4:0] phy_addr,
   // Status inputs
   input wire logic       ms_fault_evt,
   input wire logic       ms_is_master,
   input wire logic       local_rx_ok,
   input wire logic       remote_rx_ok,
   input wire logic       lp_gig_fd,
   input wire logic       lp_gig_hd,
   input wire logic       idle_err_evt
);
   timeunit 1ns;
   timeprecision 1ps;
   import pgs_pkg::*;
   logic        mdc_q, oe_q;  // Previous pin levels
   logic [15:0] hdr;          // Line bits taken at each rise
   logic [16:0] dsh;          // Block output bits at each rise
   logic [3:0]  age;          // Cycles since last rise
   logic [4:0]  rcnt, ra_q;   // Rises in an answer, its offset
   logic        flt_p, flt_c; // Pending and captured fault
   logic [7:0]  cnt_p, cnt_c; // Pending and captured idle errors
   logic [4:0]  sts_c;        // Live status at answer start
   wire rise   = mdc & ~mdc_q;                                // Raw clock rise
   wire rd_go  = mdio_oe & ~oe_q;                             // Answer starts
   wire sts_rd = rd_go & (hdr[5:1] == PGS_OFS_LINK_STATUS);   // Status read
   // Frame watcher state
   always_ff @(posedge clk) begin
      if (rst) begin
         {mdc_q, oe_q, hdr, dsh, age, rcnt, ra_q} <= '0;
         {flt_p, flt_c, cnt_p, cnt_c, sts_c} <= '0;
      end else begin
         mdc_q <= mdc;
         oe_q  <= mdio_oe;
         if (rise) hdr <= {hdr[14:0], mdio_i};
         if (rise) dsh <= {dsh[15:0], mdio_o};
         age   <= rise ? 4'h0 : age + {3'h0, age != 4'hf};
         rcnt  <= mdio_oe ? rcnt + {4'h0, rise} : 5'h00;
         if (rd_go) ra_q <= hdr[5:1];
         if (rd_go) sts_c <= {ms_is_master, local_rx_ok, remote_rx_ok, lp_gig_fd, lp_gig_hd};
         if (sts_rd) flt_c <= flt_p;
         if (sts_rd) cnt_c <= cnt_p;
         flt_p <= ms_fault_evt | (flt_p & ~sts_rd);
         cnt_p <= sts_rd ? 8'h00 : cnt_p + {7'h0, idle_err_evt & (cnt_p != 8'hff)};
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_ans_start;
      $rose(mdio_oe);
   endsequence
   sequence s_ans_end;
      $fell(mdio_oe);
   endsequence
   // Answer word of one offset under a mask
   property p_word(a, m, v);
      s_ans_end ##0 (ra_q == a) |-> ((dsh[15:0] & m) == v);
   endproperty
   AST_ANS_HDR: assert property (s_ans_start |-> hdr[14:11] == 4'h6 && hdr[10:6] == phy_addr)
      else $error("answer without a valid read header");
   AST_ANS_TIME: assert property (s_ans_start |-> !mdio_o && age inside {[1:6]})
      else $error("answer start not tied to a clock rise");
   AST_ANS_LEN: assert property (s_ans_end |-> rcnt == 5'd17)
      else $error("answer not seventeen periods long");
   AST_CAPAB: assert property (p_word(5'h0f, 16'hffff, 16'h3000))
      else $error("capability word wrong");
   AST_STS_RSVD: assert property (p_word(5'h0a, 16'h0300, 16'h0000))
      else $error("status reserved bits set");
   AST_CTRL_RSVD: assert property (p_word(5'h0d, 16'h3fe0, 16'h0000))
      else $error("control reserved bits set");
   AST_STS_LIVE: assert property (p_word(5'h0a, 16'h7c00, {1'b0, sts_c, 10'h000}))
      else $error("status live bits wrong");
   AST_STS_EVT: assert property (p_word(5'h0a, 16'h80ff, {flt_c, 7'h00, cnt_c}))
      else $error("fault flag or idle count wrong");
   AST_UNMAP: assert property (s_ans_end ##0 !(ra_q inside {5'h0a, 5'h0d, 5'h0e, 5'h0f})
      |-> dsh[15:0] == 16'h0000)
      else $error("unmapped offset not zero");
endmodule
bind pgs_regbank pgs_chk pgs_chk_i (.clk, .rst, .mdc, .mdio_i, .mdio_o, .mdio_oe,
   .phy_addr, .ms_fault_evt, .ms_is_master, .local_rx_ok, .remote_rx_ok, .lp_gig_fd,
   .lp_gig_hd, .idle_err_evt);

// [pgs_sta_mdl.sv]
// Management controller model that sends serial management frames
module pgs_sta_mdl (
   // Clock
   input  wire logic clk,
   // Management pins
   output logic      mdc,
   output logic      mdio_i,
   input  wire logic mdio_o,
   input  wire logic mdio_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   import pgs_pkg::*;
   logic h_oe;   // Controller drives the line
   logic h_d;    // Controller data bit
   logic smp;    // Line level just before a rise
   logic ta_smp; // Second turnaround bit
   logic bad_op; // Send the reserved opcode 11 instead
   // Line level: block, controller, else pull-up
   assign mdio_i = mdio_oe ? mdio_o : (h_oe ? h_d : 1'b1);
   // Clock stands low between frames
   initial begin
      mdc  = 1'b0;
      h_oe = 1'b0;
      h_d  = 1'b1;
   end
   // One bit period: low half, sample, high half
   task automatic cyc(input logic oe, input logic d);
      mdc  = 1'b0;
      h_oe = oe;
      h_d  = d;
      repeat (4) @(negedge clk);
      smp = mdio_i;
      mdc = 1'b1;
      repeat (4) @(negedge clk);
   endtask
   // Whole frame to one of the 32 direct offsets
   task automatic xfer(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [13:0] hd;
      hd = {2'b01, bad_op ? 2'b11 : (wr ? PGS_OP_WRITE : PGS_OP_READ), pa, ra};
      for (int i = 0; i < 32; i++) cyc(1'b1, 1'b1);
      for (int i = 13; i >= 0; i--) cyc(1'b1, hd[i]);
      cyc(wr, 1'b1);
      cyc(wr, 1'b0);
      ta_smp = smp;
      for (int i = 15; i >= 0; i--) begin
         cyc(wr, wd[i]);
         rd[i] = smp;
      end
      h_oe = 1'b0;
      mdc  = 1'b0;
      repeat (4) @(negedge clk);
   endtask
endmodule

// [pgs_sync.sv]
// Two flip-flop synchroniser for pin inputs, one chain per bit
module pgs_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Asynchronous input and synchronised output
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   genvar i;
   // One two-stage chain per bit; the first stage feeds only the second
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_reg;
         always_ff @(posedge clk) begin
            if (rst) begin
               meta_reg <= 1'b0;
               q[i]     <= 1'b0;
            end else begin
               meta_reg <= d[i];
               q[i]     <= meta_reg;
            end
         end
      end
   endgenerate
endmodule

// [tb_phy_gig_status_ext_access.sv]
// Self-checking bench for the gigabit status and extended access block
module tb_phy_gig_status_ext_access;
   timeunit 1ns;
   timeprecision 1ps;
   import pgs_pkg::*;
   logic        clk, rst, mdc, mdio_i, mdio_o, mdio_oe; // Clock, reset, pins
   logic [4:0]  phy_addr;                               // Strapped address
   logic        ms_fault_evt, ms_is_master, local_rx_ok; // Status inputs
   logic        remote_rx_ok, lp_gig_fd, lp_gig_hd, idle_err_evt;
   logic [15:0] rd, ex;                                 // Seen and expected
   logic [15:0] mem [0:255];                            // Model memory
   int          err_total, checks_done, seed;           // Counters and seed
   int          m_func, m_target_device_address, m_ptr, m_flt, m_cnt;   // Model state
   // Block and management controller
   pgs_regbank #(.EXT_AW(8)) pgs_regbank_i (.clk, .rst, .mdc, .mdio_i, .mdio_o, .mdio_oe,
      .phy_addr, .ms_fault_evt, .ms_is_master, .local_rx_ok, .remote_rx_ok, .lp_gig_fd,
      .lp_gig_hd, .idle_err_evt);
   pgs_sta_mdl pgs_sta_mdl_i (.clk, .mdc, .mdio_i, .mdio_o, .mdio_oe);
   // Clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Watchdog
   initial begin
      #600000;
      err_total++;
      test_done();
   end
   // Verdict and end of run
   task automatic test_done();
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // One comparison
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   // Reference model of one register access
   task automatic mdl(input logic wr, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] e);
      int ix;
      ix = m_ptr & 255;
      e  = 16'h0000;
      case (ra)
         5'h0a: begin
            e = {m_flt[0], ms_is_master, local_rx_ok, remote_rx_ok, lp_gig_fd, lp_gig_hd,
                 2'b00, m_cnt[7:0]};
            if (!wr) m_flt = 0;
            if (!wr) m_cnt = 0;
         end
         5'h0d: begin
            e = {m_func[1:0], 9'h000, m_target_device_address[4:0]};
            if (wr) m_func = wd[15:14];
            if (wr) m_target_device_address = wd[4:0];
         end
         5'h0e: if (m_target_device_address == 31 && m_func == 0) begin
            e = m_ptr[15:0];
            if (wr) m_ptr = wd;
         end else if (m_target_device_address == 31) begin
            e = mem[ix];
            if (wr) mem[ix] = wd;
            if (m_func == 2 || (m_func == 3 && wr)) m_ptr = (m_ptr + 1) & 16'hffff;
         end
         5'h0f: e = 16'h3000;
         default: e = 16'h0000;
      endcase
   endtask
   // Frame through the controller; read answers compared with the model
   task automatic acc(input logic wr, input logic [4:0] ra, input logic [15:0] wd);
      mdl(wr, ra, wd, ex);
      pgs_sta_mdl_i.xfer(wr, phy_addr, ra, wd, rd);
      if (!wr) chk($sformatf("offset %h", ra), ex, rd);
      if (!wr) chk("turnaround", 16'h0000, {15'h0000, pgs_sta_mdl_i.ta_smp});
   endtask
   // Report pointer, load a new one, pick a function
   task automatic setp(input logic [15:0] p, input logic [1:0] f);
      acc(1'b1, PGS_OFS_ACC_CTRL, 16'h001f);
      acc(1'b0, PGS_OFS_ADDR_DATA, 16'h0000);
      acc(1'b1, PGS_OFS_ADDR_DATA, p);
      acc(1'b1, PGS_OFS_ACC_CTRL, {f, 14'h001f});
   endtask
   // Fault held and idle errors for n cycles
   task automatic evt(input int f, input int n);
      ms_fault_evt = f[0];
      idle_err_evt = (n > 0);
      repeat (n > 0 ? n : 1) @(negedge clk);
      ms_fault_evt = 1'b0;
      idle_err_evt = 1'b0;
      m_flt = m_flt | f;
      m_cnt = (m_cnt + n > 255) ? 255 : m_cnt + n;
   endtask
   // Main sequence
   initial begin
      seed = 32'h7c5e;
      {err_total, checks_done, m_func, m_target_device_address, m_ptr, m_flt, m_cnt} = '0;
      rst = 1'b1;
      phy_addr = 5'h05;
      pgs_sta_mdl_i.bad_op = 1'b0;
      {ms_fault_evt, ms_is_master, local_rx_ok, remote_rx_ok} = 4'h0;
      {lp_gig_fd, lp_gig_hd, idle_err_evt} = 3'h0;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      acc(1'b0, PGS_OFS_ACC_CTRL, 16'h0000);
      acc(1'b1, PGS_OFS_CAPAB, 16'hffff);
      acc(1'b1, PGS_OFS_LINK_STATUS, 16'hffff);
      acc(1'b0, PGS_OFS_CAPAB, 16'h0000);
      acc(1'b0, 5'h15, 16'h0000);
      acc(1'b1, PGS_OFS_ACC_CTRL, 16'hffff);
      acc(1'b0, PGS_OFS_ACC_CTRL, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         {ms_is_master, local_rx_ok, remote_rx_ok, lp_gig_fd, lp_gig_hd} = 5'($random(seed));
         evt(k & 1, k * 90);
         acc(1'b0, PGS_OFS_LINK_STATUS, 16'h0000);
         acc(1'b0, PGS_OFS_LINK_STATUS, 16'h0000);
      end
      for (int f = 1; f < 4; f++) begin
         setp(16'h0120 + 16'(f * 8), 2'(f));
         repeat (3) acc(1'b1, PGS_OFS_ADDR_DATA, 16'($random(seed)));
         setp(16'h0120 + 16'(f * 8), 2'(f));
         repeat (3) acc(1'b0, PGS_OFS_ADDR_DATA, 16'h0000);
      end
      setp(16'h0128, 2'h1);
      acc(1'b1, PGS_OFS_ACC_CTRL, 16'h4005);
      acc(1'b1, PGS_OFS_ADDR_DATA, 16'hbeef);
      acc(1'b0, PGS_OFS_ADDR_DATA, 16'h0000);
      acc(1'b1, PGS_OFS_ACC_CTRL, 16'h401f);
      acc(1'b0, PGS_OFS_ADDR_DATA, 16'h0000);
      acc(1'b1, PGS_OFS_ACC_CTRL, 16'h0005);
      acc(1'b1, PGS_OFS_ADDR_DATA, 16'h0077);
      acc(1'b1, PGS_OFS_ACC_CTRL, 16'h001f);
      acc(1'b0, PGS_OFS_ADDR_DATA, 16'h0000);
      pgs_sta_mdl_i.bad_op = 1'b1;
      pgs_sta_mdl_i.xfer(1'b1, phy_addr, PGS_OFS_ACC_CTRL, 16'h8000, rd);
      pgs_sta_mdl_i.bad_op = 1'b0;
      pgs_sta_mdl_i.xfer(1'b1, phy_addr ^ 5'h01, PGS_OFS_ACC_CTRL, 16'h8000, rd);
      acc(1'b0, PGS_OFS_ACC_CTRL, 16'h0000);
      test_done();
   end
endmodule
